/* rtl/awu_map.vh */
// register offsets, field positions and timing counts of the wakeup block
`ifndef AWU_MAP_VH
`define AWU_MAP_VH
`define AWU_OFF_PORTA     12'h000
`define AWU_OFF_KBSC      12'h004
`define AWU_OFF_KBIE      12'h008
`define AWU_OFF_OPT1      12'h00c
`define AWU_OFF_OPT2      12'h010
`define AWU_OFF_ISTAT     12'h014
`define AWU_OFF_IEN       12'h018
`define AWU_OFF_ICLR      12'h01c
`define AWU_BIT_LATCH     6
`define AWU_BIT_FLAG      3
`define AWU_BIT_ACK       2
`define AWU_BIT_MASK      1
`define AWU_BIT_WIE       6
`define AWU_BIT_PSEL      7
`define AWU_BIT_OSCKEEP   4
`define AWU_SHORT_CNT     512
`define AWU_LONG_CNT      16384
`define AWU_RESP_OKAY     2'b00
`define AWU_RESP_SLVERR   2'b10
`endif

/* rtl/awu_counter.v */
// wakeup period counter with clock source select and overflow pulse
`timescale 1ns/100ps
`include "awu_map.vh"
module awu_counter #(
    parameter SHORT_CNT = `AWU_SHORT_CNT,
    parameter LONG_CNT  = `AWU_LONG_CNT
) (
    input  wire        ref_clk,
    input  wire        srst,
    input  wire        runEn,
    input  wire        oscKeepInStop,
    input  wire        periodSelect,
    input  wire        rcTick,
    input  wire        busX2Tick,
    output reg         overflow
);
    // terminal values kept at counter width so no silent truncation
    localparam [14:0] SHORT_LAST = SHORT_CNT - 1;
    localparam [14:0] LONG_LAST  = LONG_CNT - 1;

    reg  [14:0] count_r;
    wire        tick;
    wire [14:0] limit;

    // source pick: rc oscillator unless the bus clock is kept in stop
    assign tick  = oscKeepInStop ? busX2Tick : rcTick; // RULE5
    assign limit = periodSelect ? SHORT_LAST : LONG_LAST; // RULE8 RULE15

    // counter held at zero outside stop so every entry starts fresh
    always @(posedge ref_clk) begin
        if (srst || !runEn) begin
            count_r  <= 15'h0000; // RULE11 RULE13
            overflow <= 1'b0;
        end else begin
            overflow <= 1'b0;
            if (tick) begin
                if (count_r == limit) begin
                    count_r  <= 15'h0000;
                    overflow <= 1'b1; // RULE6
                end else begin
                    count_r <= count_r + 15'h0001;
                end
            end
        end
    end
endmodule // awu_counter

/* rtl/awu_wakeup.v */
// stop-mode auto wakeup timer with keyboard interrupt sharing
`timescale 1ns/100ps
`include "awu_map.vh"
// Summary of operation
// RULE1: stop entry enables wakeup request generation
// RULE2: enable bit gates the wakeup interrupt input
// RULE3: request with enable set sets latch
// RULE4: latch reads at port A bit six
// RULE5: keep bit picks rc or doubled bus clock
// RULE6: counter overflow latches and forwards request
// RULE7: serviced only with enable, keyboard vector
// RULE8: select one short period, zero long
// RULE9: acknowledge or reset clears the latch
// RULE10: latch readback ignores the enable bit
// RULE11: counters idle in run mode
// RULE12: nothing happens in wait mode
// RULE13: counters restart from zero each stop
// RULE14: wake from stop only when unmasked
// RULE15: short 512, long 16384 source cycles
// RULE16: pending flag shows keyboard or wakeup request
// RULE17: acknowledge bit always reads zero
// RULE18: mask set blocks all keyboard requests; irq still rises on a key request through intStat_r bit1
// RULE19: request equals latch, enable, unmasked, plus keys
module awu_wakeup #(
    parameter SHORT_CNT = `AWU_SHORT_CNT,
    parameter LONG_CNT  = `AWU_LONG_CNT
) (
    input  wire        ref_clk,
    input  wire        srst,
    input  wire        stopMode,
    input  wire        waitMode,
    input  wire        rcOscPin,
    input  wire        busX2Tick,
    input  wire        keyRequest,
    output wire        kbdIrqReq,
    output wire        stopWake,
    output wire        irq,
    input  wire [11:0] s_axi_awaddr,
    input  wire        s_axi_awvalid,
    output wire        s_axi_awready,
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    input  wire        s_axi_wvalid,
    output wire        s_axi_wready,
    output reg  [1:0]  s_axi_bresp,
    output reg         s_axi_bvalid,
    input  wire        s_axi_bready,
    input  wire [11:0] s_axi_araddr,
    input  wire        s_axi_arvalid,
    output wire        s_axi_arready,
    output reg  [31:0] s_axi_rdata,
    output reg  [1:0]  s_axi_rresp,
    output reg         s_axi_rvalid,
    input  wire        s_axi_rready
);
    reg         wakeupLatch_r;
    reg         irqMask_r;
    reg         wakeupIrqEnable_r;
    reg         periodSelect_r;
    reg         oscKeepInStop_r;
    reg         keyPend_r;
    reg  [1:0]  intStat_r;
    reg  [1:0]  intEn_r;
    reg  [2:0]  rcSync_r;
    reg         rcLevel_r;
    reg         awHeld_r;
    reg         wHeld_r;
    reg  [11:0] awAddr_r;
    reg  [31:0] wData_r;
    reg  [3:0]  wStrb_r;
    reg  [31:0] rdNxt;
    reg         rdOk;
    wire        runEn;
    wire        rcTick;
    wire        wakeupRequest;
    wire        wrFire;
    wire        wrOk;
    wire        ackWrite;
    wire        pendingFlag;
    wire [1:0]  events;

    // wakeup logic runs only in stop; wait mode keeps it parked
    assign runEn = stopMode && !waitMode; // RULE1 RULE11 RULE12

    // rc oscillator pin is asynchronous: three flops, edge once 2nd/3rd agree
    always @(posedge ref_clk) begin
        if (srst) begin
            rcSync_r  <= 3'h0;
            rcLevel_r <= 1'b0;
        end else begin
            rcSync_r <= {rcSync_r[1:0], rcOscPin};
            if (rcSync_r[1] == rcSync_r[2])
                rcLevel_r <= rcSync_r[2];
        end
    end
    assign rcTick = (rcSync_r[1] == rcSync_r[2]) && rcSync_r[2] && !rcLevel_r;

    awu_counter #(
        .SHORT_CNT     (SHORT_CNT),
        .LONG_CNT      (LONG_CNT)
    ) u_counter (
        .ref_clk       (ref_clk),
        .srst          (srst),
        .runEn         (runEn),
        .oscKeepInStop (oscKeepInStop_r),
        .periodSelect  (periodSelect_r),
        .rcTick        (rcTick),
        .busX2Tick     (busX2Tick),
        .overflow      (wakeupRequest)
    );

    // bus write: address and data caught in either order
    assign s_axi_awready = !awHeld_r && !s_axi_bvalid;
    assign s_axi_wready  = !wHeld_r && !s_axi_bvalid;
    assign wrFire   = awHeld_r && wHeld_r && !s_axi_bvalid;
    assign wrOk     = awAddr_r == `AWU_OFF_KBSC || awAddr_r == `AWU_OFF_KBIE
                   || awAddr_r == `AWU_OFF_OPT1 || awAddr_r == `AWU_OFF_OPT2
                   || awAddr_r == `AWU_OFF_IEN  || awAddr_r == `AWU_OFF_ICLR
                   || awAddr_r == `AWU_OFF_PORTA;
    assign ackWrite = wrFire && awAddr_r == `AWU_OFF_KBSC && wStrb_r[0]
                   && wData_r[`AWU_BIT_ACK];

    always @(posedge ref_clk) begin
        if (srst) begin
            awHeld_r     <= 1'b0;
            wHeld_r      <= 1'b0;
            awAddr_r     <= 12'h000;
            wData_r      <= 32'h00000000;
            wStrb_r      <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= `AWU_RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                awHeld_r <= 1'b1;
                awAddr_r <= {s_axi_awaddr[11:2], 2'b00};
            end
            if (s_axi_wvalid && s_axi_wready) begin
                wHeld_r <= 1'b1;
                wData_r <= s_axi_wdata;
                wStrb_r <= s_axi_wstrb;
            end
            if (wrFire) begin
                awHeld_r     <= 1'b0;
                wHeld_r      <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wrOk ? `AWU_RESP_OKAY : `AWU_RESP_SLVERR;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // software registers; port A bit six has no writable storage
    always @(posedge ref_clk) begin
        if (srst) begin
            irqMask_r         <= 1'b0;
            wakeupIrqEnable_r <= 1'b0;
            periodSelect_r    <= 1'b0;
            oscKeepInStop_r   <= 1'b0;
            intEn_r           <= 2'h0;
        end else if (wrFire && wStrb_r[0]) begin
            case (awAddr_r)
                `AWU_OFF_KBSC: irqMask_r <= wData_r[`AWU_BIT_MASK];
                `AWU_OFF_KBIE:
                    wakeupIrqEnable_r <= wData_r[`AWU_BIT_WIE]; // RULE2
                `AWU_OFF_OPT1: periodSelect_r <= wData_r[`AWU_BIT_PSEL];
                `AWU_OFF_OPT2: oscKeepInStop_r <= wData_r[`AWU_BIT_OSCKEEP];
                `AWU_OFF_IEN:  intEn_r <= wData_r[1:0];
                default: ;
            endcase
        end
    end

    // latch: set wins over a same-cycle acknowledge so no wakeup is lost
    always @(posedge ref_clk) begin
        if (srst) begin
            wakeupLatch_r <= 1'b0; // RULE9
        end else if (wakeupRequest && wakeupIrqEnable_r && runEn) begin
            wakeupLatch_r <= 1'b1; // RULE3 RULE6
        end else if (ackWrite) begin
            wakeupLatch_r <= 1'b0; // RULE9
        end
    end

    // keyboard pin request held until acknowledge, set wins again
    always @(posedge ref_clk) begin
        if (srst)
            keyPend_r <= 1'b0;
        else if (keyRequest)
            keyPend_r <= 1'b1;
        else if (ackWrite)
            keyPend_r <= 1'b0;
    end

    assign pendingFlag = keyPend_r || (wakeupLatch_r && wakeupIrqEnable_r);
    // shared keyboard vector request, masked as a whole
    assign kbdIrqReq = !irqMask_r
                    && (keyPend_r || (wakeupLatch_r && wakeupIrqEnable_r));
    // RULE7 RULE18 RULE19 (line above)
    assign stopWake = stopMode && kbdIrqReq; // RULE14

    // sticky status: bit0 wakeup latch set, bit1 keyboard pin request
    assign events = {keyRequest, wakeupRequest && wakeupIrqEnable_r && runEn};
    always @(posedge ref_clk) begin
        if (srst)
            intStat_r <= 2'h0;
        else if (wrFire && wStrb_r[0] && awAddr_r == `AWU_OFF_ICLR)
            intStat_r <= (intStat_r & ~wData_r[1:0]) | events;
        else
            intStat_r <= intStat_r | events;
    end
    assign irq = |(intStat_r & intEn_r);

    // read mux; clear register and unmapped words read zero
    always @* begin
        rdNxt = 32'h00000000;
        rdOk  = 1'b1;
        case ({s_axi_araddr[11:2], 2'b00})
            `AWU_OFF_PORTA: rdNxt[`AWU_BIT_LATCH] = wakeupLatch_r; // RULE4 RULE10
            `AWU_OFF_KBSC: begin
                rdNxt[`AWU_BIT_FLAG] = pendingFlag; // RULE16
                rdNxt[`AWU_BIT_MASK] = irqMask_r; // ack reads 0: RULE17
            end
            `AWU_OFF_KBIE:  rdNxt[`AWU_BIT_WIE] = wakeupIrqEnable_r;
            `AWU_OFF_OPT1:  rdNxt[`AWU_BIT_PSEL] = periodSelect_r;
            `AWU_OFF_OPT2:  rdNxt[`AWU_BIT_OSCKEEP] = oscKeepInStop_r;
            `AWU_OFF_ISTAT: rdNxt[1:0] = intStat_r;
            `AWU_OFF_IEN:   rdNxt[1:0] = intEn_r;
            `AWU_OFF_ICLR:  rdNxt = 32'h00000000;
            default:        rdOk = 1'b0;
        endcase
    end

    assign s_axi_arready = !s_axi_rvalid;
    always @(posedge ref_clk) begin
        if (srst) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h00000000;
            s_axi_rresp  <= `AWU_RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= rdNxt;
            s_axi_rresp  <= rdOk ? `AWU_RESP_OKAY : `AWU_RESP_SLVERR;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end
endmodule // awu_wakeup

/* bench/awu_wakeup_asserts.sv */
// checker for the wakeup block request outputs and register bus
`timescale 1ns/100ps
module awu_chk (
    input wire        ref_clk,
    input wire        srst,
    input wire        stopMode,
    input wire        kbdIrqReq,
    input wire        stopWake,
    input wire        irq,
    input wire        s_axi_awvalid,
    input wire        s_axi_awready,
    input wire        s_axi_wvalid,
    input wire        s_axi_wready,
    input wire [1:0]  s_axi_bresp,
    input wire        s_axi_bvalid,
    input wire        s_axi_bready,
    input wire        s_axi_arvalid,
    input wire        s_axi_arready,
    input wire [31:0] s_axi_rdata,
    input wire [1:0]  s_axi_rresp,
    input wire        s_axi_rvalid,
    input wire        s_axi_rready
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (srst);
    // first edge after reset must see both bus responses, irq and kbdIrqReq idle
    property p_rst;
        $past(srst) |-> !s_axi_bvalid && !s_axi_rvalid && !irq && !kbdIrqReq;
    endproperty
    a_rst: assert property (p_rst) else $error("busy after reset");
    property p_wake;
        stopWake == (stopMode && kbdIrqReq);
    endproperty
    a_wake: assert property (p_wake) else $error("wake mismatch");
    property p_rlat;
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
    endproperty
    a_rlat: assert property (p_rlat) else $error("read late");
    property p_wlat;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
            |-> ##2 s_axi_bvalid;
    endproperty
    a_wlat: assert property (p_wlat) else $error("write late");
    property p_rhold;
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
    endproperty
    a_rhold: assert property (p_rhold) else $error("rdata moved");
    property p_bhold;
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
    endproperty
    a_bhold: assert property (p_bhold) else $error("bresp moved");
    property p_bblk;
        s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
    endproperty
    a_bblk: assert property (p_bblk) else $error("ready in resp");
    // refused reads return zero data
    property p_err;
        s_axi_rvalid && s_axi_rresp == 2'b10 |-> s_axi_rdata == 32'h0;
    endproperty
    a_err: assert property (p_err) else $error("error data");
    c_wake: cover property ($rose(stopWake));
    c_irq: cover property ($rose(irq));
    c_err: cover property (s_axi_rvalid && s_axi_rresp == 2'b10);
endmodule // awu_chk
bind awu_wakeup awu_chk u_chk (.*);

/* bench/tb.sv */
// self-checking bench for the stop-mode wakeup block
`timescale 1ns/100ps
`include "awu_map.vh"
module tb;
    reg ref_clk = 1'b0, srst = 1'b1, stopMode = 1'b0, waitMode = 1'b0;
    reg rcOscPin = 1'b0, busX2Tick = 1'b0, keyReq = 1'b0;
    reg awVld = 1'b0, wVld = 1'b0, bRdy = 1'b0, arVld = 1'b0, rRdy = 1'b0;
    reg [11:0] awAddr = 12'h0, arAddr = 12'h0;
    reg [31:0] wData = 32'h0, got;
    reg [7:0]  ph = 8'h0;
    reg [1:0]  resp;
    wire       awRdy, wRdy, bVld, arRdy, rVld, kbd, wake, irq;
    wire [1:0] bResp, rResp;
    wire [31:0] rData;
    integer    fails = 0, compares = 0, n;
    awu_wakeup #(.SHORT_CNT(4), .LONG_CNT(16)) i_dut (
        .ref_clk(ref_clk), .srst(srst), .stopMode(stopMode),
        .waitMode(waitMode), .rcOscPin(rcOscPin), .busX2Tick(busX2Tick),
        .keyRequest(keyReq), .kbdIrqReq(kbd), .stopWake(wake), .irq(irq),
        .s_axi_awaddr(awAddr), .s_axi_awvalid(awVld), .s_axi_awready(awRdy),
        .s_axi_wdata(wData), .s_axi_wstrb(4'hf), .s_axi_wvalid(wVld),
        .s_axi_wready(wRdy), .s_axi_bresp(bResp), .s_axi_bvalid(bVld),
        .s_axi_bready(bRdy), .s_axi_araddr(arAddr), .s_axi_arvalid(arVld),
        .s_axi_arready(arRdy), .s_axi_rdata(rData), .s_axi_rresp(rResp),
        .s_axi_rvalid(rVld), .s_axi_rready(rRdy));
    always #10 ref_clk = ~ref_clk;
    // bus ticks every other cycle, slow rc oscillator, both free running
    always @(posedge ref_clk) begin
        ph <= ph + 8'h01;
        busX2Tick <= ph[0];
        rcOscPin <= ph[3];
    end
    task ck(input [31:0] g, input [31:0] e);
        begin
            compares = compares + 1;
            if (g !== e) begin
                fails = fails + 1;
                $display("[ERR] %0t got %h exp %h", $time, g, e);
            end
        end
    endtask
    task wr(input [11:0] a, input [31:0] d);
        integer k;
        begin
            @(posedge ref_clk);
            awAddr <= a;
            wData <= d;
            awVld <= 1'b1;
            wVld <= 1'b1;
            bRdy <= 1'b1;
            k = 0;
            do begin
                @(posedge ref_clk);
                if (awRdy) awVld <= 1'b0;
                if (wRdy) wVld <= 1'b0;
                k = k + 1;
            end while (bVld !== 1'b1 && k < 40);
            bRdy <= 1'b0;
            ck({31'h0, bVld}, 32'h1);
        end
    endtask
    task rd(input [11:0] a);
        integer k;
        begin
            @(posedge ref_clk);
            arAddr <= a;
            arVld <= 1'b1;
            rRdy <= 1'b1;
            k = 0;
            do begin
                @(posedge ref_clk);
                if (arRdy) arVld <= 1'b0;
                k = k + 1;
            end while (rVld !== 1'b1 && k < 40);
            rRdy <= 1'b0;
            got = rData;
            resp = rResp;
        end
    endtask
    task cyc(input integer m);
        repeat (m) @(posedge ref_clk);
    endtask
    // time from stop entry to wake request, then leave stop and acknowledge
    task meas;
        begin
            stopMode <= 1'b1;
            n = 0;
            do begin
                @(posedge ref_clk);
                n = n + 1;
            end while (wake !== 1'b1 && n < 100);
            stopMode <= 1'b0;
            wr(`AWU_OFF_KBSC, 32'h4);
            wr(`AWU_OFF_ICLR, 32'h1);
        end
    endtask
    task stop_test;
        begin
            $display("compares %0d fails %0d", compares, fails);
            if (fails == 0 && compares > 0)
                $display("*** PASS ***");
            else
                $display("*** FAIL ***");
            $finish;
        end
    endtask
    // whole run is about a thousand cycles, so this 20000-cycle margin is generous
    initial begin
        #400000;
        fails = fails + 1;
        stop_test;
    end
    initial begin
        cyc(20);
        srst <= 1'b0;
        rd(`AWU_OFF_PORTA); ck(got, 32'h0);
        rd(`AWU_OFF_KBSC); ck(got, 32'h0);
        rd(12'h100); ck({resp, got[29:0]}, 32'h80000000);
        $display("reset test done");
        wr(`AWU_OFF_KBIE, 32'h40);
        wr(`AWU_OFF_IEN, 32'h1);
        wr(`AWU_OFF_OPT1, 32'h80);
        cyc(100);
        rd(`AWU_OFF_PORTA); ck(got, 32'h0);
        stopMode <= 1'b1;
        n = 0;
        while (wake !== 1'b1 && n < 200) begin
            @(posedge ref_clk);
            n = n + 1;
        end
        ck(wake, 32'h1);
        rd(`AWU_OFF_PORTA); ck(got, 32'h40);
        rd(`AWU_OFF_KBSC); ck(got, 32'h8);
        ck(irq, 32'h1);
        stopMode <= 1'b0;
        wr(`AWU_OFF_KBSC, 32'h4);
        rd(`AWU_OFF_PORTA); ck(got, 32'h0);
        rd(`AWU_OFF_KBSC); ck(got, 32'h0);
        wr(`AWU_OFF_ICLR, 32'h1); ck(irq, 32'h0);
        $display("wake test done");
        wr(`AWU_OFF_KBSC, 32'h2);
        stopMode <= 1'b1;
        cyc(200);
        ck({wake, kbd}, 32'h0);
        rd(`AWU_OFF_PORTA); ck(got, 32'h40);
        wr(`AWU_OFF_KBIE, 32'h0);
        rd(`AWU_OFF_PORTA); ck(got, 32'h40);
        wr(`AWU_OFF_KBSC, 32'h6);
        wr(`AWU_OFF_KBSC, 32'h0);
        cyc(200);
        rd(`AWU_OFF_PORTA); ck(got, 32'h0);
        ck(kbd, 32'h0);
        stopMode <= 1'b0;
        $display("mask test done");
        wr(`AWU_OFF_KBIE, 32'h40);
        waitMode <= 1'b1;
        stopMode <= 1'b1;
        cyc(200);
        rd(`AWU_OFF_PORTA); ck(got, 32'h0);
        stopMode <= 1'b0;
        waitMode <= 1'b0;
        $display("wait test done");
        // keyboard pin request shares the flag and the request output
        @(posedge ref_clk);
        keyReq <= 1'b1;
        @(posedge ref_clk);
        keyReq <= 1'b0;
        @(posedge ref_clk);
        ck(kbd, 32'h1);
        rd(`AWU_OFF_KBSC); ck(got, 32'h8);
        rd(`AWU_OFF_ISTAT); ck(got & 32'h2, 32'h2);
        wr(`AWU_OFF_KBSC, 32'h4); ck(kbd, 32'h0);
        wr(`AWU_OFF_ICLR, 32'h3);
        $display("key test done");
        wr(`AWU_OFF_OPT2, 32'h10);
        meas; ck(n < 16, 32'h1);
        wr(`AWU_OFF_OPT1, 32'h0);
        meas; ck(n >= 28 && n <= 40, 32'h1);
        stopMode <= 1'b1;
        cyc(20);
        stopMode <= 1'b0;
        cyc(2);
        meas; ck(n >= 28 && n <= 40, 32'h1);
        $display("period test done");
        stop_test;
    end
endmodule // tb
